// ### hw/cfpe_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cfpe_ctrl import cfpe_pkg::*; #(
	parameter int NUM_SECTORS = DEF_SECTORS,
	parameter int OP_CYCLES = OP_MAX_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire cfpe_req_t req,
	output logic req_ready,
	input wire logic rd_valid,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic rd_ready,
	output logic rd_done,
	output logic [7:0] rd_data,
	output logic rd_refused,
	input wire logic in_circuit_serial_programming_clk,
	input wire logic in_circuit_serial_programming_data,
	input wire logic in_circuit_serial_programming_active,
	input wire logic flash_low_supply_guard,
	output logic [ADDR_W-1:0] arr_addr,
	output logic [8*PAGE_BYTES-1:0] arr_wdata,
	output logic [PAGE_BYTES-1:0] arr_wmask,
	output logic arr_prog,
	output logic arr_erase,
	output cfpe_ekind_t arr_erase_kind,
	input wire logic [7:0] arr_rdata,
	output var cfpe_status_t status,
	output logic [31:0] crc_result,
	output logic crc_valid,
	output logic [7:0] boot_vector,
	output logic [ADDR_W-1:0] boot_addr,
	output logic [NUM_SECTORS-1:0] sec_flags
);
	// ----------------------------------------
	// derived sizes
	// ----------------------------------------
	localparam int SW = $clog2(NUM_SECTORS);
	localparam logic [ADDR_W-1:0] TOTAL_A = ADDR_W'(NUM_SECTORS * SECTOR_BYTES);
	localparam logic [ADDR_W-1:0] SECT_LEN = ADDR_W'(SECTOR_BYTES);
	localparam logic [ADDR_W-1:0] LOADER_BASE = ADDR_W'(NUM_SECTORS * SECTOR_BYTES - LOADER_BYTES);
	localparam logic [OP_CNT_W-1:0] OP_LAST = OP_CNT_W'(OP_CYCLES - 1);
	localparam logic [4:0] SER_LAST = 5'(SER_FRAME_BITS - 1);

	// refuse shapes the decode cannot serve
	if (!(NUM_SECTORS inside {2, 4, 8}) || OP_CYCLES < 1 || OP_CYCLES > OP_MAX_CYCLES) begin : g_bad
		$error("cfpe_ctrl: unsupported NUM_SECTORS or OP_CYCLES");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic low_meta, low_s; // supply detector
	logic sclk_meta, sclk_s, sclk_q; // serial clock
	logic sdat_meta, sdat_s; // serial data
	logic sact_meta, sact_s; // frame enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{low_meta, low_s, sclk_meta, sclk_s, sdat_meta, sdat_s} <= 6'h00;
			{sact_meta, sact_s} <= 2'h0;
		end else begin
			low_meta <= flash_low_supply_guard;
			low_s <= low_meta;
			sclk_meta <= in_circuit_serial_programming_clk;
			sclk_s <= sclk_meta;
			sdat_meta <= in_circuit_serial_programming_data;
			sdat_s <= sdat_meta;
			sact_meta <= in_circuit_serial_programming_active;
			sact_s <= sact_meta;
		end
	end

	// ----------------------------------------
	// state and shared signals
	// ----------------------------------------
	cfpe_state_t st;
	cfpe_cmd_t op_cmd; // command in flight
	cfpe_err_t next_err;
	logic op_done; // one-cycle end pulse
	cfpe_err_t op_err; // outcome, held until next take
	cfpe_req_t cur, ser_req;
	logic [SER_FRAME_BITS-1:0] ser_sh;
	logic [4:0] ser_cnt;
	logic ser_pend, ser_rise;
	logic idle, take_ser, take, rd_take, go_work, go_crc, prog_end;
	logic [OP_CNT_W-1:0] op_cnt;
	logic [ADDR_W-1:0] work_addr, iss_left, fed_left;
	cfpe_ekind_t work_kind;
	logic [SW-1:0] cur_sec;
	logic in_rng, secured, iss, crc_p1, crc_fin;
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] loaded;
	logic rd_p0, rd_p1, rd_bad0, rd_bad1;

	// ----------------------------------------
	// serial programming frame receiver
	// ----------------------------------------
	assign ser_rise = sclk_s & ~sclk_q;
	// one frame stays pending; a later frame is dropped until it is taken
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sclk_q <= 1'b0;
			ser_sh <= '0;
			ser_cnt <= 5'h00;
			ser_pend <= 1'b0;
			ser_req <= '0;
		end else begin
			sclk_q <= sclk_s;
			if (take_ser) begin
				ser_pend <= 1'b0;
			end
			if (!sact_s) begin
				ser_cnt <= 5'h00; // framing restarts
			end else if (ser_rise) begin
				ser_sh <= {ser_sh[SER_FRAME_BITS-2:0], sdat_s};
				if (ser_cnt == SER_LAST) begin
					ser_cnt <= 5'h00;
					if (!ser_pend || take_ser) begin
						ser_pend <= 1'b1; // set wins over take
						ser_req <= cfpe_req_t'({ser_sh[SER_FRAME_BITS-2:0], sdat_s});
					end
				end else begin
					ser_cnt <= ser_cnt + 5'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// arbitration: serial first, then calls, then reads
	// ----------------------------------------
	assign idle = (st == ST_IDLE);
	assign take_ser = idle & ser_pend;
	assign take = take_ser | (idle & req_valid);
	assign cur = take_ser ? ser_req : req;
	assign req_ready = idle & ~ser_pend;
	assign rd_ready = idle & ~ser_pend & ~req_valid;
	assign rd_take = rd_valid & rd_ready;

	// ----------------------------------------
	// decode of the fixed routine set
	// ----------------------------------------
	assign cur_sec = cur.addr[SECTOR_AW +: SW];
	assign in_rng = cur.addr < TOTAL_A;
	assign secured = sec_flags[cur_sec];
	always_comb begin
		next_err = ERR_NONE;
		go_work = 1'b0;
		go_crc = 1'b0;
		work_kind = EK_NONE;
		work_addr = {cur.addr[ADDR_W-1:PAGE_AW], 6'h00};
		case (cur.cmd)
			CMD_LOAD: begin
				if (!in_rng) next_err = ERR_BAD;
			end
			CMD_PROG, CMD_ER_PAGE, CMD_ER_BYTE, CMD_ER_SECT, CMD_SEC_WR: begin
				// priority: range, supply, security, empty buffer
				if (!in_rng) next_err = ERR_BAD;
				else if (low_s) next_err = ERR_LOW;
				else if (secured && cur.cmd != CMD_ER_SECT && cur.cmd != CMD_SEC_WR)
					next_err = ERR_SEC;
				else if (cur.cmd == CMD_PROG && loaded == '0) next_err = ERR_EMPTY;
				else go_work = (cur.cmd != CMD_SEC_WR);
				if (cur.cmd == CMD_ER_SECT) begin
					work_kind = EK_SECTOR;
					work_addr = {cur.addr[ADDR_W-1:SECTOR_AW], 10'h000};
				end else if (cur.cmd == CMD_ER_PAGE) begin
					work_kind = EK_PAGE;
				end else if (cur.cmd == CMD_ER_BYTE) begin
					work_kind = EK_BYTE;
					work_addr = cur.addr;
				end
			end
			CMD_CRC_SECT: begin
				if (!in_rng) next_err = ERR_BAD;
				else go_crc = 1'b1;
			end
			CMD_CRC_ALL: go_crc = 1'b1;
			CMD_BOOT_WR: next_err = ERR_NONE;
			default: next_err = ERR_BAD; // unknown routine
		endcase
	end

	// ----------------------------------------
	// sequencer: timed strobes, crc walk, reads
	// ----------------------------------------
	assign prog_end = (st == ST_WORK) && !low_s && (op_cnt == OP_LAST);
	assign crc_fin = (st == ST_CRC) && crc_p1 && (fed_left == 16'h0001);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= ST_IDLE;
			op_cmd <= CMD_NOP;
			op_cnt <= '0;
			arr_addr <= 16'h0000;
			arr_prog <= 1'b0;
			arr_erase <= 1'b0;
			arr_erase_kind <= EK_NONE;
			op_done <= 1'b0;
			op_err <= ERR_NONE;
			iss <= 1'b0;
			iss_left <= 16'h0000;
			fed_left <= 16'h0000;
		end else begin
			op_done <= 1'b0;
			iss <= 1'b0;
			case (st)
				ST_IDLE: begin
					if (take) begin
						op_cmd <= cur.cmd;
						op_cnt <= '0;
						op_err <= next_err;
						if (go_work) begin
							st <= ST_WORK; // busy from here
							arr_addr <= work_addr;
							arr_prog <= (cur.cmd == CMD_PROG);
							arr_erase <= (cur.cmd != CMD_PROG);
							arr_erase_kind <= work_kind;
						end else if (go_crc) begin
							st <= ST_CRC;
							iss <= 1'b1;
							arr_addr <= (cur.cmd == CMD_CRC_ALL) ? 16'h0000 :
								{cur.addr[ADDR_W-1:SECTOR_AW], 10'h000};
							iss_left <= ((cur.cmd == CMD_CRC_ALL) ? TOTAL_A : SECT_LEN) - 16'h0001;
							fed_left <= (cur.cmd == CMD_CRC_ALL) ? TOTAL_A : SECT_LEN;
						end else begin
							op_done <= 1'b1; // immediate or rejected
						end
					end else if (rd_take) begin
						arr_addr <= rd_addr;
					end
				end
				ST_WORK: begin
					if (low_s || op_cnt == OP_LAST) begin
						// supply loss aborts at once
						st <= ST_IDLE;
						arr_prog <= 1'b0;
						arr_erase <= 1'b0;
						arr_erase_kind <= EK_NONE;
						op_done <= 1'b1;
						if (low_s) op_err <= ERR_LOW;
					end else begin
						op_cnt <= op_cnt + 20'h00001;
					end
				end
				ST_CRC: begin
					if (iss_left != 16'h0000) begin
						iss <= 1'b1;
						arr_addr <= arr_addr + 16'h0001;
						iss_left <= iss_left - 16'h0001;
					end
					if (crc_p1) fed_left <= fed_left - 16'h0001;
					if (crc_fin) begin
						st <= ST_IDLE;
						op_done <= 1'b1;
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end
	// one driver for the whole status word; busy follows the state at once
	assign status = '{busy: !idle, done: op_done, err: op_err};

	// ----------------------------------------
	// page buffer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			loaded <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) pbuf[i] <= 8'h00;
		end else if (take && cur.cmd == CMD_LOAD && next_err == ERR_NONE) begin
			pbuf[cur.addr[PAGE_AW-1:0]] <= cur.data;
			loaded[cur.addr[PAGE_AW-1:0]] <= 1'b1;
		end else if (prog_end && op_cmd == CMD_PROG) begin
			loaded <= '0; // buffer spent; aborted program keeps it
		end
	end
	for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_wdata
		assign arr_wdata[g*8 +: 8] = pbuf[g];
	end
	assign arr_wmask = loaded;

	// ----------------------------------------
	// security bits and boot vector
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sec_flags <= {NUM_SECTORS{SEC_RESET}};
			boot_vector <= LOADER_BASE[ADDR_W-1:8];
		end else begin
			if (take && cur.cmd == CMD_SEC_WR && next_err == ERR_NONE)
				sec_flags[cur_sec] <= cur.data[0];
			// a finished sector erase also lifts that sector's lock
			if (prog_end && op_cmd == CMD_ER_SECT)
				sec_flags[arr_addr[SECTOR_AW +: SW]] <= 1'b0;
			if (take && cur.cmd == CMD_BOOT_WR)
				boot_vector <= cur.data;
		end
	end
	assign boot_addr = {boot_vector, BOOT_LOW};

	// ----------------------------------------
	// table reads, three edges from take to answer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			{rd_p0, rd_p1, rd_bad0, rd_bad1, rd_done, rd_refused} <= 6'h00;
			rd_data <= 8'h00;
		end else begin
			rd_p0 <= rd_take;
			rd_bad0 <= (rd_addr >= TOTAL_A) || sec_flags[rd_addr[SECTOR_AW +: SW]];
			rd_p1 <= rd_p0;
			rd_bad1 <= rd_bad0;
			rd_done <= rd_p1;
			rd_refused <= rd_p1 & rd_bad1;
			if (rd_p1) rd_data <= rd_bad1 ? 8'h00 : arr_rdata;
		end
	end

	// ----------------------------------------
	// crc engine
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			crc_p1 <= 1'b0;
			crc_valid <= 1'b0;
		end else begin
			crc_p1 <= iss; // array answers one edge after address
			if (take && go_crc) crc_valid <= 1'b0;
			else if (crc_fin) crc_valid <= 1'b1;
		end
	end
	cfpe_crc32 u_crc (
		.core_clk(core_clk),
		.rst(rst),
		.clear(take && go_crc),
		.en(crc_p1),
		.data_in(arr_rdata),
		.crc(crc_result)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [OP_CNT_W-1:0] str_cnt; // strobe run length
	always_ff @(posedge core_clk) begin
		if (rst) str_cnt <= '0;
		else str_cnt <= (arr_prog || arr_erase) ? str_cnt + 20'h00001 : '0;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_busy_refuse: assert property (status.busy |-> !req_ready && !rd_ready)
		else $error("request accepted while busy");
	a_busy_end: assert property ($fell(status.busy) |-> status.done)
		else $error("busy ended without done");
	a_low_block: assert property (low_s |=> !(arr_prog || arr_erase))
		else $error("strobe held during low supply");
	a_op_bound: assert property (str_cnt <= OP_CNT_W'(OP_CYCLES))
		else $error("operation exceeded time limit");
	a_prog_page: assert property (arr_prog |-> arr_wmask != '0 && arr_addr[PAGE_AW-1:0] == 6'h00)
		else $error("program without data or unaligned");
	a_sect_align: assert property (arr_erase && arr_erase_kind == EK_SECTOR |-> arr_addr[SECTOR_AW-1:0] == 10'h000)
		else $error("sector erase not aligned");
	a_byte_erase: assert property (take && cur.cmd == CMD_ER_BYTE && next_err == ERR_NONE
		|=> arr_erase && arr_erase_kind == EK_BYTE && arr_addr == $past(cur.addr))
		else $error("byte erase not issued");
	a_prog_unsec: assert property (arr_prog |-> !sec_flags[arr_addr[SECTOR_AW +: SW]])
		else $error("program into secured sector");
	a_sec_read: assert property (rd_take && sec_flags[rd_addr[SECTOR_AW +: SW]] |-> ##3 rd_done && rd_refused)
		else $error("secured read not refused");
	a_open_read: assert property (rd_take && rd_addr < TOTAL_A && !sec_flags[rd_addr[SECTOR_AW +: SW]]
		|-> ##3 rd_done && !rd_refused)
		else $error("open read refused or late");
	a_boot_form: assert property (take && cur.cmd == CMD_BOOT_WR |=> boot_addr == {$past(cur.data), 8'h00})
		else $error("boot address wrong");
	a_ser_take: assert property (ser_pend && idle |=> status.busy || status.done)
		else $error("serial command not taken");
	a_crc_done: assert property ($rose(crc_valid) |-> status.done && $past(st == ST_CRC))
		else $error("crc valid without crc run");

	c_prog: cover property (prog_end && op_cmd == CMD_PROG);
	c_sect_erase: cover property (prog_end && op_cmd == CMD_ER_SECT);
	c_crc_all: cover property (crc_fin && op_cmd == CMD_CRC_ALL);
	c_refused: cover property (rd_done && rd_refused);
endmodule
`default_nettype wire

// ### hw/cfpe_pkg.sv

`default_nettype none
package cfpe_pkg;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int SECTOR_BYTES = 1024;
	localparam int PAGE_BYTES = 64;
	localparam int SECTOR_AW = 10;
	localparam int PAGE_AW = 6;
	localparam int ADDR_W = 16;
	localparam int LOADER_BYTES = 512;
	localparam int DEF_SECTORS = 8;
	localparam logic [7:0] BOOT_LOW = 8'h00;
	localparam logic SEC_RESET = 1'b0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int T_OP_MAX_MS = 2;
	localparam int CLK_MHZ = 250;
	// longest time, so the count rounds down (exact here)
	localparam int OP_MAX_CYCLES = T_OP_MAX_MS * 1000 * CLK_MHZ;
	localparam int OP_CNT_W = 20;

	// ----------------------------------------
	// serial frame and crc
	// ----------------------------------------
	localparam int SER_FRAME_BITS = 28;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;

	// ----------------------------------------
	// commands, errors, states
	// ----------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0, CMD_LOAD = 4'h1, CMD_PROG = 4'h2, CMD_ER_SECT = 4'h3,
		CMD_ER_PAGE = 4'h4, CMD_ER_BYTE = 4'h5, CMD_CRC_SECT = 4'h6,
		CMD_CRC_ALL = 4'h7, CMD_SEC_WR = 4'h8, CMD_BOOT_WR = 4'h9
	} cfpe_cmd_t;
	typedef enum logic [2:0] {
		ERR_NONE = 3'h0, ERR_LOW = 3'h1, ERR_SEC = 3'h2, ERR_BAD = 3'h3, ERR_EMPTY = 3'h4
	} cfpe_err_t;
	typedef enum logic [1:0] {
		EK_NONE = 2'h0, EK_SECTOR = 2'h1, EK_PAGE = 2'h2, EK_BYTE = 2'h3
	} cfpe_ekind_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_WORK = 3'b010, ST_CRC = 3'b100
	} cfpe_state_t;

	// request word, also the serial frame, msb first
	typedef struct packed {
		cfpe_cmd_t cmd;
		logic [15:0] addr;
		logic [7:0] data;
	} cfpe_req_t;
	typedef struct packed {
		logic busy;
		logic done;
		cfpe_err_t err;
	} cfpe_status_t;
endpackage
`default_nettype wire

// ### hw/cfpe_crc32.sv
`timescale 1ns/1ps
`default_nettype none
module cfpe_crc32 import cfpe_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic en,
	input wire logic [7:0] data_in,
	output logic [31:0] crc
);
	// ----------------------------------------
	// one byte step, lsb first, reflected
	// ----------------------------------------
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			// shift out one bit, fold poly on mismatch
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ----------------------------------------
	// running remainder, no final inversion
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			crc <= CRC_INIT;
		end else if (clear) begin
			crc <= CRC_INIT; // clear beats data
		end else if (en) begin
			crc <= crc_step(crc, data_in);
		end
	end
endmodule
`default_nettype wire

// ### dv/cfpe_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// flash array stand-in on the far side
// ----------------------------------------
module cfpe_flash_model import cfpe_pkg::*; (
	input wire logic core_clk,
	input wire logic [ADDR_W-1:0] arr_addr,
	input wire logic [8*PAGE_BYTES-1:0] arr_wdata,
	input wire logic [PAGE_BYTES-1:0] arr_wmask,
	input wire logic arr_prog,
	input wire logic arr_erase,
	input wire cfpe_ekind_t arr_erase_kind,
	output logic [7:0] arr_rdata
);
	logic [7:0] mem [0:8191]; // eight sectors of cells
	logic prog_q = 1'b0; // strobe history, act once per pulse
	logic ers_q = 1'b0;
	logic [12:0] ea; // first byte hit by an erase
	int j;
	int k;
	// non-blank pattern, so a crc or a read of it means something
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 8'(i * 7 + 3);
		end
	end
	// synchronous read, one edge behind the address
	always_ff @(posedge core_clk) begin
		arr_rdata <= mem[arr_addr[12:0]];
	end
	// program only clears bits, as real cells do; erase sets ff
	always @(posedge core_clk) begin
		prog_q <= arr_prog;
		ers_q <= arr_erase;
		if (arr_prog && !prog_q) begin
			for (j = 0; j < PAGE_BYTES; j++) begin
				if (arr_wmask[j]) begin
					mem[{arr_addr[12:6], 6'(j)}] = mem[{arr_addr[12:6], 6'(j)}] & arr_wdata[8*j+:8];
				end
			end
		end
		if (arr_erase && !ers_q) begin
			case (arr_erase_kind)
				EK_SECTOR: ea = {arr_addr[12:10], 10'h000};
				EK_PAGE: ea = {arr_addr[12:6], 6'h00};
				default: ea = arr_addr[12:0];
			endcase
			k = (arr_erase_kind == EK_SECTOR) ? SECTOR_BYTES :
				(arr_erase_kind == EK_PAGE) ? PAGE_BYTES : 1;
			for (j = 0; j < k; j++) begin
				mem[13'(ea + j)] = 8'hff;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import cfpe_pkg::*;;
	localparam int OPC = 20; // shortened program/erase hold
	logic core_clk, rst, req_valid, rd_valid, flash_low_supply_guard;
	logic in_circuit_serial_programming_clk, in_circuit_serial_programming_data;
	logic in_circuit_serial_programming_active;
	cfpe_req_t req;
	logic [15:0] rd_addr, arr_addr, boot_addr;
	logic req_ready, rd_ready, rd_done, rd_refused, arr_prog, arr_erase, crc_valid;
	logic [7:0] rd_data, arr_rdata, boot_vector, sec_flags;
	logic [511:0] arr_wdata, r_wdata;
	logic [63:0] arr_wmask, r_mask;
	logic [31:0] crc_result, ex;
	cfpe_ekind_t arr_erase_kind, r_kind;
	cfpe_status_t status;
	cfpe_err_t r_err; // outcome of the last request
	logic [15:0] r_addr;
	int r_strobe, r_cyc;
	int num_errors = 0;
	int checks = 0;
	// ----------------------------------------
	// clock, design and array model
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	cfpe_ctrl #(.NUM_SECTORS(8), .OP_CYCLES(OPC)) dut_u (
		.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_done(rd_done),
		.rd_data(rd_data), .rd_refused(rd_refused),
		.in_circuit_serial_programming_clk(in_circuit_serial_programming_clk),
		.in_circuit_serial_programming_data(in_circuit_serial_programming_data),
		.in_circuit_serial_programming_active(in_circuit_serial_programming_active),
		.flash_low_supply_guard(flash_low_supply_guard), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .arr_wmask(arr_wmask), .arr_prog(arr_prog), .arr_erase(arr_erase),
		.arr_erase_kind(arr_erase_kind), .arr_rdata(arr_rdata), .status(status),
		.crc_result(crc_result), .crc_valid(crc_valid), .boot_vector(boot_vector),
		.boot_addr(boot_addr), .sec_flags(sec_flags));
	cfpe_flash_model flash_u (
		.core_clk(core_clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wmask(arr_wmask),
		.arr_prog(arr_prog), .arr_erase(arr_erase), .arr_erase_kind(arr_erase_kind),
		.arr_rdata(arr_rdata));
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// a used-up wait bound ends the run as a mismatch
	task automatic hang();
		chk(1'b0, 1'b1);
		summarize();
	endtask
	// one routine call; records strobe length, address and outcome
	task automatic run_req(input cfpe_cmd_t c, input logic [15:0] a, input logic [7:0] d,
		input int lim);
		int n;
		logic fin;
		@(negedge core_clk);
		req_valid = 1'b1;
		req = '{cmd: c, addr: a, data: d};
		n = 0;
		while (req_ready !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 50) hang();
		end
		@(negedge core_clk);
		req_valid = 1'b0;
		r_strobe = 0;
		fin = 1'b0;
		for (n = 0; n < lim && !fin; n++) begin
			if (arr_prog === 1'b1 || arr_erase === 1'b1) begin
				r_strobe++;
				r_addr = arr_addr;
				r_kind = arr_erase_kind;
				r_mask = arr_wmask;
				r_wdata = arr_wdata;
			end
			if (status.busy === 1'b1) chk({req_ready, rd_ready}, 2'b00);
			if (status.done === 1'b1) begin
				fin = 1'b1;
				r_err = status.err;
				r_cyc = n;
			end else begin
				@(negedge core_clk);
			end
		end
		if (!fin) hang();
	endtask
	// one table read, judged on refusal flag and data
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic refused);
		int n;
		@(negedge core_clk);
		rd_valid = 1'b1;
		rd_addr = a;
		n = 0;
		while (rd_ready !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 50) hang();
		end
		@(negedge core_clk);
		rd_valid = 1'b0;
		n = 0;
		while (rd_done !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 8) hang();
		end
		chk(rd_refused, refused);
		chk(rd_data, exp);
	endtask
	// reflected crc of the model's cells, no final xor
	function automatic logic [31:0] crc_of(input int base, input int len);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < len; i++) begin
			c ^= {24'h0, flash_u.mem[base + i]};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(boot_vector, 8'((DEF_SECTORS * SECTOR_BYTES - LOADER_BYTES) >> 8));
		chk(boot_addr, 16'(DEF_SECTORS * SECTOR_BYTES - LOADER_BYTES));
		chk(sec_flags, 8'h00);
		chk(status, 5'h00);
		$display("test reset finished");
	endtask
	task automatic t_erase();
		cfpe_cmd_t c[3] = '{CMD_ER_SECT, CMD_ER_PAGE, CMD_ER_BYTE};
		cfpe_ekind_t k[3] = '{EK_SECTOR, EK_PAGE, EK_BYTE};
		logic [15:0] ra[3] = '{16'h0445, 16'h0845, 16'h0c45};
		logic [15:0] ea[3] = '{16'h0400, 16'h0840, 16'h0c45};
		for (int i = 0; i < 3; i++) begin
			run_req(c[i], ra[i], 8'h00, 200);
			chk(r_err, ERR_NONE);
			chk(r_kind, k[i]);
			chk(r_addr, ea[i]);
			chk(r_strobe, OPC);
			chk(r_cyc, OPC);
		end
		rd(16'h0c45, 8'hff, 1'b0);
		rd(16'h0c46, 8'(16'h0c46 * 7 + 3), 1'b0);
		rd(16'h087f, 8'hff, 1'b0);
		$display("test erase finished");
	endtask
	task automatic t_prog();
		run_req(CMD_LOAD, 16'h0003, 8'h12, 10);
		run_req(CMD_LOAD, 16'h003f, 8'h34, 10);
		run_req(CMD_PROG, 16'h0847, 8'h00, 200);
		chk(r_mask, 64'h8000000000000008);
		chk(r_wdata[8*3+:8], 8'h12);
		chk(r_addr, 16'h0840);
		chk(r_strobe, OPC);
		rd(16'h0843, 8'h12, 1'b0);
		rd(16'h087f, 8'h34, 1'b0);
		run_req(CMD_PROG, 16'h0840, 8'h00, 200);
		chk(r_err, ERR_EMPTY);
		$display("test program finished");
	endtask
	task automatic t_sec();
		run_req(CMD_SEC_WR, 16'h0400, 8'h01, 10);
		chk(sec_flags, 8'h02);
		rd(16'h0410, 8'h00, 1'b1);
		rd(16'h0010, 8'h73, 1'b0);
		rd(16'h2000, 8'h00, 1'b1);
		run_req(CMD_LOAD, 16'h0000, 8'h00, 10);
		run_req(CMD_PROG, 16'h0400, 8'h00, 200);
		chk(r_err, ERR_SEC);
		run_req(cfpe_cmd_t'(4'hc), 16'h0000, 8'h00, 10);
		chk(r_err, ERR_BAD);
		run_req(CMD_ER_SECT, 16'h0400, 8'h00, 200);
		chk(sec_flags, 8'h00);
		rd(16'h0410, 8'hff, 1'b0);
		$display("test security finished");
	endtask
	task automatic t_low();
		cfpe_cmd_t c[4] = '{CMD_PROG, CMD_ER_SECT, CMD_ER_BYTE, CMD_SEC_WR};
		// supply drops mid-erase: strobe must end early with a low-supply outcome
		fork
			run_req(CMD_ER_BYTE, 16'h0841, 8'h00, 200);
			begin
				repeat (3) @(negedge core_clk);
				flash_low_supply_guard = 1'b1;
			end
		join
		chk(r_err, ERR_LOW);
		chk(r_strobe < OPC, 1'b1);
		@(negedge core_clk);
		flash_low_supply_guard = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 4; i++) begin
			run_req(c[i], 16'h0840, 8'h01, 200);
			chk(r_err, ERR_LOW);
			chk(r_strobe, 0);
		end
		flash_low_supply_guard = 1'b0;
		repeat (4) @(negedge core_clk);
		$display("test low supply finished");
	endtask
	task automatic t_crc();
		ex = crc_of(16'h0c00, SECTOR_BYTES);
		run_req(CMD_CRC_SECT, 16'h0c00, 8'h00, 1200);
		chk(crc_valid, 1'b1);
		chk(crc_result, ex);
		ex = crc_of(0, 8 * SECTOR_BYTES);
		run_req(CMD_CRC_ALL, 16'h0000, 8'h00, 9000);
		chk(crc_result, ex);
		$display("test crc finished");
	endtask
	task automatic t_serial();
		logic [27:0] f;
		int n;
		f = {CMD_BOOT_WR, 16'h0000, 8'h40};
		@(negedge core_clk);
		in_circuit_serial_programming_active = 1'b1;
		for (int i = 27; i >= 0; i--) begin
			in_circuit_serial_programming_data = f[i];
			repeat (4) @(negedge core_clk);
			in_circuit_serial_programming_clk = 1'b1;
			repeat (4) @(negedge core_clk);
			in_circuit_serial_programming_clk = 1'b0;
		end
		in_circuit_serial_programming_data = ~f[0];
		repeat (4) @(negedge core_clk);
		in_circuit_serial_programming_active = 1'b0;
		n = 0;
		while (boot_vector !== 8'h40) begin
			@(negedge core_clk);
			n++;
			if (n > 20) hang();
		end
		chk(boot_vector, 8'h40);
		chk(boot_addr, 16'h4000);
		$display("test serial finished");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		rd_valid = 1'b0;
		rd_addr = 16'h0000;
		flash_low_supply_guard = 1'b0;
		in_circuit_serial_programming_clk = 1'b0;
		in_circuit_serial_programming_data = 1'b0;
		in_circuit_serial_programming_active = 1'b0;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		t_reset();
		t_erase();
		t_prog();
		t_sec();
		t_low();
		t_crc();
		t_serial();
		summarize();
	end
endmodule
`default_nettype wire
